//--- tcf_pkg.sv
// Shared constants for the transmit cell FIFO write port and GFC insertion link
package tcf_pkg;
	// ------------------------------------------------------------
	// Cell and FIFO geometry
	// ------------------------------------------------------------
	localparam logic [5:0] CELL_LAST = 6'h34;      // 53 octets, index 0..52
	localparam logic [7:0] FIFO_BYTES = 8'hd4;     // Four cells of 53 octets
	localparam logic [7:0] FIFO_LAST = 8'hd3;
	localparam logic [3:0][8:0] DEPTH_CAP = {9'h0d4, 9'h09f, 9'h06a, 9'h035};
	localparam logic [8:0] NEAR_SLACK = 9'h004;    // Writes still allowed after near-full
	// ------------------------------------------------------------
	// Transmit byte timing
	// ------------------------------------------------------------
	localparam logic [2:0] BYTE_DIV_LAST = 3'h7;   // Line clock divided by eight
	localparam logic [2:0] BYTE_DIV_HALF = 3'h4;
	localparam logic [5:0] PULSE_OCT = 6'h2f;      // Six octets before next cell start
	localparam logic [2:0] GFC_CAP_START = 3'h5;   // One idle period, then four bits
	localparam logic [2:0] GFC_BITS = 3'h4;
	// ------------------------------------------------------------
	// Idle cell content
	// ------------------------------------------------------------
	localparam logic [5:0] IDLE_HDR_OCTS = 6'h04;
	localparam logic [5:0] IDLE_HEC_OCT = 6'h04;
	localparam logic [7:0] IDLE_HEC = 8'h00;
	localparam logic [7:0] IDLE_PAYLOAD = 8'h6a;
	// ------------------------------------------------------------
	// Writer side write clock
	// ------------------------------------------------------------
	localparam logic [2:0] WCLK_DIV_LAST = 3'h7;
	localparam logic [2:0] WCLK_FALL = 3'h3;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic AVAIL_RST = 1'b1;
	localparam logic WEN_N_RST = 1'b1;
endpackage : tcf_pkg

//--- tcf_link_if.sv
// Link between the cell writer and the transmit cell FIFO
`timescale 1ns/1ps
interface tcf_link_if;
	logic fifo_write_clock;
	logic fifo_write_enable_n;
	logic [7:0] tx_cell_data_bus;
	logic tx_start_of_cell;
	logic tx_cell_available;
	logic tx_byte_clock;
	logic tx_cell_pulse;
	logic tx_gfc_serial_in;

	modport dev_mp (
		input fifo_write_clock,
		input fifo_write_enable_n,
		input tx_cell_data_bus,
		input tx_start_of_cell,
		output tx_cell_available,
		output tx_byte_clock,
		output tx_cell_pulse,
		input tx_gfc_serial_in
	);

	modport atm_mp (
		output fifo_write_clock,
		output fifo_write_enable_n,
		output tx_cell_data_bus,
		output tx_start_of_cell,
		input tx_cell_available,
		input tx_byte_clock,
		input tx_cell_pulse,
		output tx_gfc_serial_in
	);
endinterface : tcf_link_if

//--- tcf_atm_end.sv
// Cell writer end: drives the FIFO write port and serves GFC bits
`timescale 1ns/1ps
module tcf_atm_end (
	input wire logic SYS_CLK_I,            // System clock
	input wire logic RESET_N_I,            // Async reset, active low
	tcf_link_if.atm_mp link,               // Link to the FIFO end
	input wire logic CELL_VALID_I,         // Byte waiting to be written
	input wire logic [7:0] CELL_BYTE_I,    // Byte to write, cell order
	input wire logic CFG_AVAIL_ACTIVE_LOW_I, // Cell-available polarity
	input wire logic [3:0] GFC_VALUE_I,    // GFC for the next cell
	output logic CELL_BYTE_READY_O         // Byte taken, one-cycle pulse
);
	typedef struct packed {
		logic [2:0] div;
		logic wclk;
		logic wen_n;
		logic [7:0] data;
		logic soc;
		logic [5:0] cnt;
		logic ready;
		logic bclk_q;
		logic [3:0] gfc_sh;
		logic [2:0] gfc_cnt;
		logic gfc_bit;
	} tcf_atm_st_t;

	tcf_atm_st_t r;
	tcf_atm_st_t n;
	logic fall;
	logic brise;
	logic avail_on;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.ready = 1'b0;
		n.bclk_q = link.tx_byte_clock;
		n.div = (r.div == tcf_pkg::WCLK_DIV_LAST) ? 3'h0 : r.div + 3'h1;
		fall = (r.div == tcf_pkg::WCLK_FALL);
		if (fall) begin
			n.wclk = 1'b0;
		end else if (r.div == tcf_pkg::WCLK_DIV_LAST) begin
			n.wclk = 1'b1;
		end
		avail_on = link.tx_cell_available ^ CFG_AVAIL_ACTIVE_LOW_I;
		// Data changes on the falling edge so it is stable at the rising edge
		if (fall) begin
			// A cell once begun is finished even after cell-available drops
			if (CELL_VALID_I && (r.cnt != 6'h0 || avail_on)) begin // [RULE_08]
				n.wen_n = 1'b0; // [RULE_22]
				n.data = CELL_BYTE_I;
				n.soc = (r.cnt == 6'h0); // [RULE_01]
				n.cnt = (r.cnt == tcf_pkg::CELL_LAST) ? 6'h0 : r.cnt + 6'h1;
				n.ready = 1'b1;
			end else begin
				n.wen_n = 1'b1; // [RULE_22]
				n.soc = 1'b0;
			end
		end
		brise = link.tx_byte_clock & ~r.bclk_q;
		if (brise) begin
			if (r.gfc_cnt != 3'h0) begin
				n.gfc_bit = r.gfc_sh[3]; // [RULE_15]
				n.gfc_sh = {r.gfc_sh[2:0], 1'b0};
				n.gfc_cnt = r.gfc_cnt - 3'h1;
			end
			// MSB goes out in the period right after the pulse
			if (link.tx_cell_pulse) begin // [RULE_19]
				n.gfc_sh = GFC_VALUE_I;
				n.gfc_cnt = tcf_pkg::GFC_BITS;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			r <= '0;
			r.wen_n <= tcf_pkg::WEN_N_RST;
		end else begin
			r <= n;
		end
	end

	assign link.fifo_write_clock = r.wclk;
	assign link.fifo_write_enable_n = r.wen_n;
	assign link.tx_cell_data_bus = r.data;
	assign link.tx_start_of_cell = r.soc;
	assign link.tx_gfc_serial_in = r.gfc_bit;
	assign CELL_BYTE_READY_O = r.ready;
endmodule : tcf_atm_end

//--- tcf_dev_end.sv
// Transmit cell FIFO end: write port, cell-available, transmit-off and GFC insertion
// Contract
// (RULE_01) Start-of-cell marks a cell's first octet
// (RULE_02) Octet counting keeps delineation without markers
// (RULE_03) Misplaced start-of-cell raises an error event
// (RULE_04) Start-of-cell sampled on write clock rise
// (RULE_05) Cell-available means room for whole cell; code compares fill to programmed depth, less four in near-full
// (RULE_06) Select near-full or full deassert meaning
// (RULE_07) Full depth programmable one to four cells
// (RULE_08) Writes still accepted after cell-available drops
// (RULE_09) Cell-available updated on write clock rise
// (RULE_10) Cell-available polarity programmable, default high
// (RULE_11) Transmit-off makes next cell idle
// (RULE_12) Idle cells continue until transmit-off drops
// (RULE_13) Transmit-off synchronised before use
// (RULE_14) Test mode turns transmit-off into vector clock
// (RULE_15) GFC bits follow the cell pulse, four periods
// (RULE_16) Per-bit enables choose serial GFC insertion
// (RULE_17) Disabled bits keep idle or written header
// (RULE_18) GFC sampled on byte clock rise
// (RULE_19) Writer drives GFC MSB right after pulse
// (RULE_20) One-period cell pulse six octets ahead
// (RULE_21) Cell pulse updated on byte clock rise
// (RULE_22) Byte written only when write enable low
// (RULE_23) Four-cell FIFO, only complete cells sent
// (RULE_24) Byte clock is line clock divided by eight
`timescale 1ns/1ps
module tcf_dev_end (
	input wire logic SYS_CLK_I,             // Synthesised line clock
	input wire logic RESET_N_I,             // Async reset, active low
	tcf_link_if.dev_mp link,                // Link to the cell writer
	input wire logic TX_OFF_I,              // Transmit off, asynchronous
	input wire logic CFG_PROD_TEST_I,       // Production test enable
	input wire logic CFG_AVAIL_NEAR_FULL_I, // 1: near-full, 0: full meaning
	input wire logic [1:0] CFG_FULL_DEPTH_I, // Full depth minus one, in cells
	input wire logic CFG_AVAIL_ACTIVE_LOW_I, // Cell-available polarity
	input wire logic [3:0] CFG_GFC_EN_I,    // Per-bit GFC insertion enable
	input wire logic [31:0] CFG_IDLE_HDR_I, // Idle cell header octets 0..3
	output logic [7:0] TX_OCTET_O,          // Outgoing cell octet
	output logic TX_OCTET_VALID_O,          // Octet strobe, one cycle per byte
	output logic TX_OCTET_SOC_O,            // Octet is first of its cell
	output logic TX_OCTET_IDLE_O,           // Octet belongs to an idle cell
	output logic SOC_ERR_O,                 // Misplaced start-of-cell, pulse
	output logic TEST_VECTOR_CLK_O          // Test vector clock in test mode
);
	typedef struct packed {
		logic [tcf_pkg::FIFO_LAST:0][7:0] mem;
		logic [7:0] wr_ptr;
		logic [7:0] rd_ptr;
		logic [7:0] used;
		logic [5:0] wr_cnt;
		logic [2:0] cells;
		logic wclk_q;
		logic off_s1;
		logic off_s2;
		logic [2:0] div;
		logic bclk;
		logic [5:0] oct;
		logic src_fifo;
		logic nxt_fifo;
		logic [3:0] gfc_sh;
		logic [2:0] gfc_cnt;
		logic pulse;
		logic avail;
		logic soc_err;
		logic [7:0] octet;
		logic octet_valid;
		logic octet_soc;
		logic octet_idle;
		logic vec_clk;
	} tcf_dev_st_t;

	tcf_dev_st_t r;
	tcf_dev_st_t n;

	function automatic logic [7:0] ptr_inc(input logic [7:0] p);
		ptr_inc = (p == tcf_pkg::FIFO_LAST) ? 8'h00 : p + 8'h01;
	endfunction : ptr_inc

	function automatic logic [7:0] ptr_back(input logic [7:0] p, input logic [5:0] k);
		logic [7:0] kk;
		kk = {2'b00, k};
		ptr_back = (p >= kk) ? p - kk : p + tcf_pkg::FIFO_BYTES - kk;
	endfunction : ptr_back

	function automatic logic [7:0] idle_byte(input logic [31:0] hdr, input logic [5:0] idx);
		logic [7:0] b;
		b = tcf_pkg::IDLE_PAYLOAD;
		if (idx < tcf_pkg::IDLE_HDR_OCTS) begin
			b = hdr[8'd31 - {idx[1:0], 3'b000} -: 8];
		end else if (idx == tcf_pkg::IDLE_HEC_OCT) begin
			b = tcf_pkg::IDLE_HEC;
		end
		idle_byte = b;
	endfunction : idle_byte

	logic off_eff;
	logic wr_rise;
	logic tick;
	logic wrap;
	logic [7:0] wptr;
	logic [7:0] used_w;
	logic [5:0] wcnt;
	logic cell_done;
	logic rd;
	logic cell_take;
	logic [5:0] oct_n;
	logic [7:0] byte_v;
	logic [8:0] cap;
	logic avail_lvl;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.soc_err = 1'b0;
		n.octet_valid = 1'b0;
		n.off_s1 = TX_OFF_I; // [RULE_13]
		n.off_s2 = r.off_s1;
		off_eff = r.off_s2 & ~CFG_PROD_TEST_I; // [RULE_14]
		n.vec_clk = r.off_s2 & CFG_PROD_TEST_I; // [RULE_14]
		n.wclk_q = link.fifo_write_clock;
		wr_rise = link.fifo_write_clock & ~r.wclk_q; // [RULE_04]
		wptr = r.wr_ptr;
		used_w = r.used;
		wcnt = r.wr_cnt;
		cell_done = 1'b0;
		// Write side: a marker mid-cell drops the partial cell and restarts
		if (wr_rise && !link.fifo_write_enable_n) begin // [RULE_22]
			if (link.tx_start_of_cell && r.wr_cnt != 6'h0) begin // [RULE_01]
				n.soc_err = 1'b1; // [RULE_03]
				wptr = ptr_back(r.wr_ptr, r.wr_cnt);
				used_w = r.used - {2'b00, r.wr_cnt};
				wcnt = 6'h0;
			end
			// Bytes are dropped only when all four cells are physically used
			if (used_w < tcf_pkg::FIFO_BYTES) begin // [RULE_08]
				n.mem[wptr] = link.tx_cell_data_bus;
				wptr = ptr_inc(wptr);
				used_w = used_w + 8'h01;
				if (wcnt == tcf_pkg::CELL_LAST) begin // [RULE_02]
					wcnt = 6'h0;
					cell_done = 1'b1; // [RULE_23]
				end else begin
					wcnt = wcnt + 6'h1;
				end
			end
		end
		n.wr_ptr = wptr;
		n.wr_cnt = wcnt;

		// Byte clock: high for the first half of every eight line clocks
		n.div = (r.div == tcf_pkg::BYTE_DIV_LAST) ? 3'h0 : r.div + 3'h1; // [RULE_24]
		n.bclk = (n.div < tcf_pkg::BYTE_DIV_HALF); // [RULE_24]
		tick = (r.div == tcf_pkg::BYTE_DIV_LAST);
		wrap = (r.oct == tcf_pkg::CELL_LAST);
		oct_n = wrap ? 6'h0 : r.oct + 6'h1;
		rd = 1'b0;
		cell_take = 1'b0;
		byte_v = 8'h00;
		if (tick) begin // [RULE_21]
			n.oct = oct_n;
			n.pulse = (oct_n == tcf_pkg::PULSE_OCT); // [RULE_20]
			if (wrap) begin
				n.src_fifo = r.nxt_fifo;
			end
			if (r.gfc_cnt != 3'h0) begin // [RULE_18]
				if (r.gfc_cnt <= tcf_pkg::GFC_BITS) begin
					n.gfc_sh = {r.gfc_sh[2:0], link.tx_gfc_serial_in}; // [RULE_15]
				end
				n.gfc_cnt = r.gfc_cnt - 3'h1;
			end
			// Source of the next cell is fixed when its pulse goes out
			if (n.pulse) begin
				cell_take = (r.cells != 3'h0) && !off_eff; // [RULE_11] [RULE_12] [RULE_23]
				n.nxt_fifo = cell_take;
				n.gfc_cnt = tcf_pkg::GFC_CAP_START;
			end
			if (n.src_fifo) begin
				byte_v = r.mem[r.rd_ptr];
				rd = 1'b1;
				n.rd_ptr = ptr_inc(r.rd_ptr);
			end else begin
				byte_v = idle_byte(CFG_IDLE_HDR_I, oct_n); // [RULE_17]
			end
			if (oct_n == 6'h0) begin
				byte_v[7:4] = (CFG_GFC_EN_I & r.gfc_sh) | (~CFG_GFC_EN_I & byte_v[7:4]); // [RULE_16] [RULE_17]
			end
			n.octet = byte_v;
			n.octet_valid = 1'b1;
			n.octet_soc = (oct_n == 6'h0);
			n.octet_idle = ~n.src_fifo;
		end
		n.used = used_w - {7'h00, rd};
		n.cells = r.cells + {2'b00, cell_done} - {2'b00, cell_take};

		// Cell-available from the programmed depth
		cap = tcf_pkg::DEPTH_CAP[CFG_FULL_DEPTH_I]; // [RULE_07]
		if (CFG_AVAIL_NEAR_FULL_I) begin
			avail_lvl = ({1'b0, n.used} + tcf_pkg::NEAR_SLACK) < cap; // [RULE_06] [RULE_05]
		end else begin
			avail_lvl = {1'b0, n.used} < cap; // [RULE_06]
		end
		if (wr_rise) begin // [RULE_09]
			n.avail = avail_lvl ^ CFG_AVAIL_ACTIVE_LOW_I; // [RULE_10]
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			r <= '0;
			r.avail <= tcf_pkg::AVAIL_RST; // [RULE_10]
			// Divider starts at wrap so the first byte clock high is full width
			r.div <= tcf_pkg::BYTE_DIV_LAST; // [RULE_24]
		end else begin
			r <= n;
		end
	end

	assign link.tx_cell_available = r.avail;
	assign link.tx_byte_clock = r.bclk;
	assign link.tx_cell_pulse = r.pulse;
	assign TX_OCTET_O = r.octet;
	assign TX_OCTET_VALID_O = r.octet_valid;
	assign TX_OCTET_SOC_O = r.octet_soc;
	assign TX_OCTET_IDLE_O = r.octet_idle;
	assign SOC_ERR_O = r.soc_err;
	assign TEST_VECTOR_CLK_O = r.vec_clk;
endmodule : tcf_dev_end

//--- tcf_monitor.sv
// Concurrent checks on the writer to FIFO link
`timescale 1ns/1ps
module tcf_monitor (
	input wire logic SYS_CLK_I,           // Clock
	input wire logic RESET_N_I,           // Reset, active low
	input wire logic fifo_write_clock,    // Write clock
	input wire logic fifo_write_enable_n, // Write enable
	input wire logic [7:0] tx_cell_data_bus, // Octet
	input wire logic tx_start_of_cell,    // First octet
	input wire logic tx_cell_available,   // Room flag
	input wire logic tx_byte_clock,       // Byte clock
	input wire logic tx_cell_pulse,       // Cell pulse
	input wire logic tx_gfc_serial_in     // GFC bit
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	logic pulse_q_r;
	logic seen_r;
	logic [9:0] gap_r;
	// ------------------------------------------------------------
	// Cycles since last cell pulse
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pulse_q_r <= 1'b0;
			seen_r <= 1'b0;
			gap_r <= 10'h000;
		end else begin
			pulse_q_r <= tx_cell_pulse;
			seen_r <= seen_r | tx_cell_pulse;
			gap_r <= (tx_cell_pulse && !pulse_q_r) ? 10'h001 : gap_r + 10'h001;
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_pulse_one_period: assert property ($rose(tx_cell_pulse) |-> tx_cell_pulse[*8] ##1 !tx_cell_pulse)
		else $error("cell pulse not one byte period");
	a_pulse_cell_gap: assert property (tx_cell_pulse && !pulse_q_r && seen_r |-> gap_r == 10'h1a8)
		else $error("cell pulses not 53 octets apart");
	a_pulse_clk_edge: assert property ($changed(tx_cell_pulse) |-> $rose(tx_byte_clock))
		else $error("cell pulse moved off byte clock rise");
	a_byte_clk_div: assert property ($rose(tx_byte_clock) |-> tx_byte_clock[*4] ##1 !tx_byte_clock[*4] ##1 tx_byte_clock)
		else $error("byte clock not divide by eight");
	a_avail_wclk_edge: assert property ($changed(tx_cell_available) |-> $past(fifo_write_clock) && !$past(fifo_write_clock, 2))
		else $error("cell available moved off write clock rise");
	a_soc_with_write: assert property (tx_start_of_cell |-> !fifo_write_enable_n)
		else $error("start of cell without a write");
	a_write_held: assert property ($rose(fifo_write_clock) |-> $stable(fifo_write_enable_n) && $stable(tx_cell_data_bus))
		else $error("write signals moved at write clock rise");
	a_gfc_held: assert property ($rose(tx_byte_clock) |-> $stable(tx_gfc_serial_in))
		else $error("GFC bit moved at byte clock rise");
	c_pulse: cover property ($rose(tx_cell_pulse));
	c_avail_drop: cover property ($changed(tx_cell_available));
	c_soc_write: cover property (tx_start_of_cell && !fifo_write_enable_n);
endmodule : tcf_monitor

//--- tx_cell_fifo_flow_gfc_tb.sv
// Self-checking bench for the FIFO write port and GFC link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tx_cell_fifo_flow_gfc_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic tx_off = 1'b1, prod_test = 1'b0, near = 1'b0, act_low = 1'b0, cell_valid = 1'b0, avail_q = 1'b0;
	logic [1:0] depth = 2'h0;
	logic [3:0] gfc_en = 4'h0, gfc = 4'h0;
	logic [31:0] hdr = 32'h0;
	logic [7:0] cell_byte = 8'h00, oct_o, e;
	logic oct_v, oct_soc, oct_idle, soc_err, tvclk, ready;
	integer seed = 32'h62c762e8;
	int miscompares = 0, samples_checked = 0, cycles = 0, nbytes = 0, drop_at = 0, idx = 0;
	logic [7:0] bq[$];
	tcf_link_if lnk();
	always #50 clk = ~clk;
	tcf_atm_end tcf_atm_end_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .link(lnk), .CELL_VALID_I(cell_valid),
		.CELL_BYTE_I(cell_byte), .CFG_AVAIL_ACTIVE_LOW_I(act_low), .GFC_VALUE_I(gfc), .CELL_BYTE_READY_O(ready));
	tcf_dev_end tcf_dev_end_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .link(lnk), .TX_OFF_I(tx_off),
		.CFG_PROD_TEST_I(prod_test), .CFG_AVAIL_NEAR_FULL_I(near), .CFG_FULL_DEPTH_I(depth),
		.CFG_AVAIL_ACTIVE_LOW_I(act_low), .CFG_GFC_EN_I(gfc_en), .CFG_IDLE_HDR_I(hdr), .TX_OCTET_O(oct_o),
		.TX_OCTET_VALID_O(oct_v), .TX_OCTET_SOC_O(oct_soc), .TX_OCTET_IDLE_O(oct_idle), .SOC_ERR_O(soc_err),
		.TEST_VECTOR_CLK_O(tvclk));
	tcf_monitor tcf_monitor_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .fifo_write_clock(lnk.fifo_write_clock),
		.fifo_write_enable_n(lnk.fifo_write_enable_n), .tx_cell_data_bus(lnk.tx_cell_data_bus),
		.tx_start_of_cell(lnk.tx_start_of_cell), .tx_cell_available(lnk.tx_cell_available),
		.tx_byte_clock(lnk.tx_byte_clock), .tx_cell_pulse(lnk.tx_cell_pulse),
		.tx_gfc_serial_in(lnk.tx_gfc_serial_in));
	// ------------------------------------------------------------
	// Reference model of the outgoing octet stream
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			report_and_stop();
		end
		if (rst_n !== 1'b1) begin
			// Octet counter leaves reset at zero, so octet one goes out first
			idx = 0;
		end else begin
			// Fill level when room flag falls, seen from the pin
			if ((lnk.tx_cell_available ^ act_low) === 1'b0 && avail_q === 1'b1) drop_at = nbytes;
			`CHK("marker error", 1'b0, soc_err)
			if (oct_v === 1'b1) begin
				idx = (idx == 52) ? 0 : idx + 1;
				`CHK("start flag", idx == 0, oct_soc)
				if (idx == 0 && tx_off) `CHK("idle while off", 1'b1, oct_idle)
				if (oct_idle === 1'b0) e = bq.size() ? bq.pop_front() : 8'hxx;
				else e = idx < 4 ? hdr[31 - 8 * idx -: 8] : idx == 4 ? tcf_pkg::IDLE_HEC : tcf_pkg::IDLE_PAYLOAD;
				if (idx == 0) e[7:4] = (gfc & gfc_en) | (e[7:4] & ~gfc_en);
				// Every whole cell has had a GFC capture behind it
				`CHK("octet", e, oct_o)
			end
		end
		avail_q = lnk.tx_cell_available ^ act_low;
	end
	task automatic restart(input int k);
		rst_n <= 1'b0;
		tx_off <= 1'b1;
		near <= (k == 4);
		depth <= (k == 4) ? 2'h3 : 2'(k);
		act_low <= k[0];
		prod_test <= (k == 5);
		gfc_en <= 4'($random(seed));
		gfc <= 4'($random(seed));
		hdr <= $random(seed);
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		bq.delete();
		nbytes = 0;
		drop_at = -1;
	endtask : restart
	// Valid stays up between cells, so no double drive at one edge
	task automatic send_cell(output bit ok);
		logic [7:0] b;
		int n;
		ok = 1'b1;
		for (int i = 0; i < 53; i++) begin
			b = 8'($random(seed));
			cell_valid <= 1'b1;
			cell_byte <= b;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (ready !== 1'b1 && n < 40);
			if (ready !== 1'b1) begin
				cell_valid <= 1'b0;
				`CHK("stall offset", 0, i)
				ok = 1'b0;
				return;
			end
			bq.push_back(b);
			nbytes++;
		end
	endtask : send_cell
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// ------------------------------------------------------------
	// Tests: depths 1..4 full, near-full, then test mode
	// ------------------------------------------------------------
	initial begin : main
		bit ok;
		int n;
		for (int k = 0; k < 5; k++) begin
			restart(k);
			repeat (16) @(posedge clk);
			`CHK("room level", ~act_low, lnk.tx_cell_available)
			ok = 1'b1;
			while (ok) send_cell(ok);
			`CHK("fill at drop", (k == 4) ? 208 : (k + 1) * 53, drop_at)
			`CHK("bytes held", (k == 4) ? 212 : (k + 1) * 53, nbytes)
			tx_off <= 1'b0;
			n = 0;
			while (bq.size() != 0 && n < 3000) begin
				@(posedge clk);
				n++;
			end
			repeat (424) @(posedge clk);
			`CHK("drained", 0, bq.size())
			$display("test %0d done", k);
		end
		restart(5);
		repeat (4) @(posedge clk);
		`CHK("vector clock high", 1'b1, tvclk)
		tx_off <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("vector clock low", 1'b0, tvclk)
		$display("test 5 done");
		report_and_stop();
	end
endmodule : tx_cell_fifo_flow_gfc_tb
